// ===== rtl/abs_pos_defs.svh
// constants shared by both ends of the absolute position link
`ifndef ABS_POS_DEFS_SVH
`define ABS_POS_DEFS_SVH
`define CLK_HZ 40000000
`define STANDBY_MS 100
`define NORMAL_DELAY_MS 400
`define BAUD_BPS 9600
`define PULSE_INTERVAL_NS 370
`define STANDBY_CYCLES ((`CLK_HZ / 1000) * `STANDBY_MS)
`define NORMAL_CYCLES ((`CLK_HZ / 1000) * `NORMAL_DELAY_MS)
`define BIT_CYCLES (`CLK_HZ / `BAUD_BPS)
`define PULSE_CYCLES ((`PULSE_INTERVAL_NS * (`CLK_HZ / 1000000)) / 1000)
`define UNIT_BITS 20
`define SERIAL_W 16
`define POS_W 40
`define RES_W 5
`define OFS_W 31
`define OFS_MIN_RAW 31'h40000000
`define OFS_NEG_LIMIT 31'h40000001
`define TIMER_W 24
`define BIT_W 13
`define PACE_W 5
`define DIGITS 5
`define DEC_BASE 10
`define FRAME_CHARS 4'h8
`define ALARM_CHARS 4'h4
`define TX_LAST_BIT 4'h9
`define RX_LAST_BIT 4'h9
`define CHAR_P 7'h50
`define CHAR_PLUS 7'h2b
`define CHAR_MINUS 7'h2d
`define CHAR_CR 7'h0d
`define CHAR_ZERO 7'h30
`define CHAR_A 7'h41
`endif

// ===== rtl/abs_pos_pkg.sv
// state types of both ends of the absolute position link
package abs_pos_pkg;
  // drive sequencer states
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_STANDBY = 3'b001,
    DEV_SEND = 3'b010,
    DEV_SETTLE = 3'b011,
    DEV_NORMAL = 3'b100,
    DEV_ALARM = 3'b101
  } dev_state_e;
  // host receiver states
  typedef enum logic [2:0] {
    HOST_IDLE = 3'b000,
    HOST_WAIT = 3'b001,
    HOST_RECV = 3'b010,
    HOST_ARM = 3'b011,
    HOST_COUNT = 3'b100
  } host_state_e;
endpackage : abs_pos_pkg

// ===== rtl/abs_link_if.sv
// wires between the drive's position output and the host controller
`timescale 1ns/100ps
interface abs_link_if;
  logic sensor_on_command; // host to drive, one-cycle pulse
  logic sensor_off_command; // host to drive, one-cycle pulse
  logic servo_on_command; // host to drive, one-cycle pulse
  logic serial_and_phase_a_out; // serial frame, then phase a
  logic phase_b_out; // phase b
  logic origin_pulse_out; // origin pulse
  modport device_mp (
    input sensor_on_command,
    input sensor_off_command,
    input servo_on_command,
    output serial_and_phase_a_out,
    output phase_b_out,
    output origin_pulse_out
  );
  modport host_mp (
    output sensor_on_command,
    output sensor_off_command,
    output servo_on_command,
    input serial_and_phase_a_out,
    input phase_b_out,
    input origin_pulse_out
  );
endinterface : abs_link_if

// ===== rtl/char_tx.sv
// asynchronous character sender: start, 7 data lsb first, even parity, stop
`timescale 1ns/100ps
`include "abs_pos_defs.svh"
module char_tx #(
  parameter int unsigned BIT_CYCLES = `BIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic [6:0] char_i,
  output logic line_o,
  output logic busy_o
);
  logic busy_q; // frame in progress
  logic [`BIT_W-1:0] tmr_q; // cycles within the bit
  logic [3:0] bit_q; // bit number in frame
  logic [9:0] sh_q; // bits still to send, lsb on the line
  wire bit_end = tmr_q == `BIT_W'(BIT_CYCLES - 1);
  wire frame_end = bit_end && (bit_q == `TX_LAST_BIT);

  // load frame on start, shift one bit per bit time, idle at mark
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_q <= 1'b0;
      tmr_q <= '0;
      bit_q <= '0;
      sh_q <= '1;
    end else if (start_i && !busy_q) begin
      busy_q <= 1'b1;
      tmr_q <= '0;
      bit_q <= '0;
      sh_q <= {1'b1, ^char_i, char_i, 1'b0};
    end else if (busy_q) begin
      tmr_q <= bit_end ? '0 : tmr_q + `BIT_W'(1);
      if (bit_end) begin
        sh_q <= {1'b1, sh_q[9:1]};
        bit_q <= bit_q + 4'h1;
      end
      if (frame_end) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign line_o = sh_q[0];
  assign busy_o = busy_q;
endmodule : char_tx

// ===== rtl/abs_pos_device.sv
// drive end: absolute position frame, initial pulses, quadrature, alarms
// Behaviour
// - a: serial then pulses; b pulses; origin
// - origin pulse width equals phase a pulse
// - origin pulse aligned to a phase edge
// - host keeps counter on origin during reception
// - standby and counter clear 100 ms after
// - eight character frame, all received before counting
// - normal pulses about 400 ms after frame
// - forward motion makes phase b lead
// - serial value is divided position over 1048576
// - remainder sent as initial pulses, 0.37 us (code steps every 14 cycles, 0.35 us at 40 MHz)
// - host combines serial, pulses and reference
// - 9600 bps, start, 7 data, even, stop
// - P, sign, five digits, carriage return
// - serial value wraps between the 16-bit limits
// - reverse direction inverts the sign character
// - sensor off sends alarm contents serially
// - sensor off refused while motor powered
// - origin offset added after sensor on
// - servo on ignored during initialization
`timescale 1ns/100ps
`include "abs_pos_defs.svh"
module abs_pos_device #(
  parameter int unsigned STANDBY_CYCLES = `STANDBY_CYCLES,
  parameter int unsigned NORMAL_CYCLES = `NORMAL_CYCLES,
  parameter int unsigned BIT_CYCLES = `BIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic signed [`POS_W-1:0] scale_position_i, // scale counts
  input wire logic [`RES_W-1:0] output_resolution_setting_i, // shift
  input wire logic direction_select_i, // 1 = reverse direction mode
  input wire logic signed [`OFS_W-1:0] origin_offset_setting_i,
  input wire logic absolute_scale_i, // scale used as absolute
  input wire logic [7:0] alarm_code_i, // alarm to report
  input wire logic servo_off_i, // de-energize request
  output logic motor_energize_o,
  output logic sensor_off_refused_o,
  output logic signed [`POS_W-1:0] machine_coordinate_position_o,
  abs_link_if.device_mp link
);
  abs_pos_pkg::dev_state_e state_q; // sequencer state
  logic [`TIMER_W-1:0] timer_q; // standby and settle timer
  logic [3:0] char_idx_q; // next character of the frame
  logic [`SERIAL_W-1:0] snap_q; // serial value being sent
  logic [7:0] alarm_q; // alarm code being sent
  logic signed [`POS_W-1:0] out_cnt_q; // position shown by the pulses
  logic [`PACE_W-1:0] pace_q; // pulse interval counter
  logic offset_en_q; // origin offset applies
  logic energize_q; // motor powered
  logic refused_q; // sensor off was refused
  logic pa_q; // phase a / serial line
  logic pb_q; // phase b line
  logic origin_q; // origin line
  logic signed [`POS_W-1:0] mc_q; // machine coordinate
  logic tx_line; // serial sender line
  logic tx_busy; // serial sender busy
  logic [6:0] tx_char; // character to send
  logic [6:0] digit_char [`DIGITS]; // decimal digits of the value

  // state decode
  wire is_idle = state_q == abs_pos_pkg::DEV_IDLE;
  wire is_standby = state_q == abs_pos_pkg::DEV_STANDBY;
  wire is_send = state_q == abs_pos_pkg::DEV_SEND;
  wire is_settle = state_q == abs_pos_pkg::DEV_SETTLE;
  wire is_normal = state_q == abs_pos_pkg::DEV_NORMAL;
  wire is_alarm = state_q == abs_pos_pkg::DEV_ALARM;
  wire pulsing = is_settle | is_normal;
  wire framing = is_send | is_alarm;
  wire in_init = is_standby | is_send | is_settle;

  // position divided by the output resolution
  wire signed [`POS_W-1:0] div_pos =
    scale_position_i >>> output_resolution_setting_i;
  wire [`SERIAL_W-1:0] div_serial =
    div_pos[`UNIT_BITS +: `SERIAL_W];

  // timing decode
  wire standby_done = timer_q == `TIMER_W'(STANDBY_CYCLES - 1);
  wire settle_done = timer_q >= `TIMER_W'(NORMAL_CYCLES - 1);
  wire timer_run = is_standby | (is_settle & ~settle_done);
  wire pace_done = pace_q == `PACE_W'(`PULSE_CYCLES - 1);
  wire caught_up = out_cnt_q == div_pos;
  wire step_up = pulsing & pace_done & (out_cnt_q < div_pos);
  wire step_dn = pulsing & pace_done & (out_cnt_q > div_pos);

  // command decode
  wire sensor_on_ok = is_idle & link.sensor_on_command;
  wire off_ok = link.sensor_off_command & absolute_scale_i &
    ~energize_q & (is_idle | is_normal);
  wire servo_on_ok = link.servo_on_command & ~in_init;

  // frame sequencing
  wire [3:0] frame_len = is_alarm ? `ALARM_CHARS : `FRAME_CHARS;
  wire chars_left = char_idx_q != frame_len;
  wire tx_start = framing & ~tx_busy & chars_left;
  wire frame_over = framing & ~tx_busy & ~chars_left;

  // magnitude of the value, -32768 included
  // invert before widening, so the top bit stays clear
  wire [`SERIAL_W:0] mag = snap_q[`SERIAL_W-1] ?
    ({1'b0, ~snap_q} + (`SERIAL_W+1)'(1)) : {1'b0, snap_q};
  wire neg_sign = snap_q[`SERIAL_W-1] ^ direction_select_i;

  // one decimal digit per place, most significant first
  for (genvar g = 0; g < `DIGITS; g++) begin : g_digit
    localparam int unsigned PLACE = `DEC_BASE ** (`DIGITS - 1 - g);
    assign digit_char[g] = `CHAR_ZERO +
      7'((32'(mag) / PLACE) % `DEC_BASE);
  end

  // ascii of one hex nibble
  function automatic logic [6:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? `CHAR_ZERO + 7'(n) : `CHAR_A + 7'(n - 4'ha);
  endfunction : hex_char

  // position frame characters
  wire [6:0] sign_char = neg_sign ? `CHAR_MINUS : `CHAR_PLUS;
  wire [6:0] pos_char =
    (char_idx_q == 4'h0) ? `CHAR_P :
    (char_idx_q == 4'h1) ? sign_char :
    (char_idx_q == `FRAME_CHARS - 4'h1) ? `CHAR_CR :
    digit_char[3'(char_idx_q - 4'h2)];
  // alarm frame characters
  wire [6:0] alm_char =
    (char_idx_q == 4'h0) ? `CHAR_A :
    (char_idx_q == 4'h1) ? hex_char(alarm_q[7:4]) :
    (char_idx_q == 4'h2) ? hex_char(alarm_q[3:0]) : `CHAR_CR;
  assign tx_char = is_alarm ? alm_char : pos_char;

  // quadrature from the shown position, up count puts b first
  wire quad_a = out_cnt_q[1];
  wire quad_b = out_cnt_q[1] ^ out_cnt_q[0];
  // origin spans counts 0 and 1: one a-low width, between a edges
  wire at_origin = out_cnt_q[`UNIT_BITS-1:1] == '0;

  // clamp the most negative code into the offset range
  wire signed [`OFS_W-1:0] ofs_c =
    (origin_offset_setting_i == `OFS_MIN_RAW) ?
    `OFS_NEG_LIMIT : origin_offset_setting_i;
  wire signed [`POS_W-1:0] ofs_ext =
    {{(`POS_W - `OFS_W){ofs_c[`OFS_W-1]}}, ofs_c};

  // serial character sender
  char_tx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) i_char_tx (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(tx_start),
    .char_i(tx_char),
    .line_o(tx_line),
    .busy_o(tx_busy)
  );

  // sequencer state, timer and character index
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= abs_pos_pkg::DEV_IDLE;
      timer_q <= '0;
      char_idx_q <= '0;
    end else begin
      timer_q <= timer_run ? timer_q + `TIMER_W'(1) :
        (is_settle ? timer_q : '0);
      char_idx_q <= framing ? char_idx_q + 4'(tx_start) : '0;
      case (state_q)
        abs_pos_pkg::DEV_IDLE: begin
          if (sensor_on_ok) begin
            state_q <= abs_pos_pkg::DEV_STANDBY;
          end else if (off_ok) begin
            state_q <= abs_pos_pkg::DEV_ALARM;
          end
        end
        abs_pos_pkg::DEV_STANDBY: begin
          if (standby_done) begin
            state_q <= abs_pos_pkg::DEV_SEND;
          end
        end
        abs_pos_pkg::DEV_SEND: begin
          if (frame_over) begin
            state_q <= abs_pos_pkg::DEV_SETTLE;
          end
        end
        abs_pos_pkg::DEV_SETTLE: begin
          if (settle_done && caught_up) begin
            state_q <= abs_pos_pkg::DEV_NORMAL;
          end
        end
        abs_pos_pkg::DEV_NORMAL: begin
          if (off_ok) begin
            state_q <= abs_pos_pkg::DEV_ALARM;
          end
        end
        abs_pos_pkg::DEV_ALARM: begin
          if (frame_over) begin
            state_q <= abs_pos_pkg::DEV_IDLE;
          end
        end
        default: begin
          state_q <= abs_pos_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // snapshot, shown position and pulse pacing
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      snap_q <= '0;
      out_cnt_q <= '0;
      pace_q <= '0;
      alarm_q <= '0;
    end else begin
      if (is_standby && standby_done) begin
        snap_q <= div_serial;
        out_cnt_q <= {div_pos[`POS_W-1:`UNIT_BITS], `UNIT_BITS'(0)};
      end else if (step_up) begin
        out_cnt_q <= out_cnt_q + `POS_W'(1);
      end else if (step_dn) begin
        out_cnt_q <= out_cnt_q - `POS_W'(1);
      end
      pace_q <= (pace_done | ~pulsing) ? '0 : pace_q + `PACE_W'(1);
      if (off_ok) begin
        alarm_q <= alarm_code_i;
      end
    end
  end

  // line drivers, motor power and machine coordinate
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pa_q <= 1'b1;
      pb_q <= 1'b0;
      origin_q <= 1'b0;
      offset_en_q <= 1'b0;
      energize_q <= 1'b0;
      refused_q <= 1'b0;
      mc_q <= '0;
    end else begin
      pa_q <= pulsing ? quad_a : tx_line;
      pb_q <= pulsing & quad_b;
      origin_q <= pulsing & at_origin;
      if (sensor_on_ok) begin
        offset_en_q <= 1'b1;
      end
      if (servo_off_i) begin
        energize_q <= 1'b0;
      end else if (servo_on_ok) begin
        energize_q <= 1'b1;
      end
      refused_q <= link.sensor_off_command & energize_q;
      mc_q <= scale_position_i + (offset_en_q ? ofs_ext : '0);
    end
  end

  assign link.serial_and_phase_a_out = pa_q;
  assign link.phase_b_out = pb_q;
  assign link.origin_pulse_out = origin_q;
  assign motor_energize_o = energize_q;
  assign sensor_off_refused_o = refused_q;
  assign machine_coordinate_position_o = mc_q;
endmodule : abs_pos_device

// ===== rtl/abs_pos_host.sv
// host end: commands, frame reception, pulse counting, absolute value
`timescale 1ns/100ps
`include "abs_pos_defs.svh"
module abs_pos_host #(
  parameter int unsigned STANDBY_CYCLES = `STANDBY_CYCLES,
  parameter int unsigned BIT_CYCLES = `BIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sensor_on_req_i,
  input wire logic sensor_off_req_i,
  input wire logic servo_on_req_i,
  input wire logic signed [`SERIAL_W-1:0] ref_serial_i, // reference value
  input wire logic [`UNIT_BITS:0] ref_pulses_i, // reference pulses
  output logic position_valid_o,
  output logic signed [`POS_W-1:0] abs_position_o,
  output logic frame_error_o,
  output logic origin_seen_o,
  abs_link_if.host_mp link
);
  abs_pos_pkg::host_state_e state_q; // receiver state
  logic [`TIMER_W-1:0] timer_q; // standby wait
  logic rx_busy_q; // character in reception
  logic [`BIT_W-1:0] rx_tmr_q; // cycles to next sample
  logic [3:0] rx_bit_q; // bit number
  logic [7:0] rx_sh_q; // data and parity
  logic [3:0] idx_q; // character number
  logic neg_q; // minus sign seen
  logic [`SERIAL_W:0] acc_q; // decimal accumulator
  logic signed [`SERIAL_W-1:0] serial_q; // received value
  logic [1:0] prev_q; // last quadrature count
  logic signed [`POS_W-1:0] pcount_q; // up/down pulse counter
  logic on_q; // command pulses
  logic off_q;
  logic servo_q;
  logic valid_q;
  logic err_q;
  logic origin_q;
  logic signed [`POS_W-1:0] pos_q;

  wire line = link.serial_and_phase_a_out;
  wire is_idle = state_q == abs_pos_pkg::HOST_IDLE;
  wire is_recv = state_q == abs_pos_pkg::HOST_RECV;
  wire is_count = state_q == abs_pos_pkg::HOST_COUNT;
  wire standby_done = timer_q == `TIMER_W'(STANDBY_CYCLES - 1);
  wire rx_tick = rx_busy_q & (rx_tmr_q == '0);
  wire rx_done = rx_tick & (rx_bit_q == `RX_LAST_BIT);
  wire [6:0] rx_char = rx_sh_q[6:0];
  wire rx_bad = ~line | (^rx_sh_q); // stop or parity fault
  wire [3:0] digit = 4'(rx_char - `CHAR_ZERO);
  wire [1:0] quad = {line, line ^ link.phase_b_out};
  wire [1:0] delta = quad - prev_q;
  wire [`SERIAL_W:0] acc_next =
    (`SERIAL_W+1)'(acc_q * `DEC_BASE) + (`SERIAL_W+1)'(digit);
  // current value and the reference, both as value*1048576+pulses
  wire signed [`POS_W-1:0] pe = {{(`POS_W-`SERIAL_W-`UNIT_BITS)
    {serial_q[`SERIAL_W-1]}}, serial_q, `UNIT_BITS'(0)} + pcount_q;
  wire signed [`POS_W-1:0] ps = {{(`POS_W-`SERIAL_W-`UNIT_BITS)
    {ref_serial_i[`SERIAL_W-1]}}, ref_serial_i, `UNIT_BITS'(0)} +
    `POS_W'(ref_pulses_i);

  // character receiver, sampled at mid bit, lsb first
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_busy_q <= 1'b0;
      rx_tmr_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
    end else if (!rx_busy_q && is_recv && !line) begin
      rx_busy_q <= 1'b1;
      rx_tmr_q <= `BIT_W'(BIT_CYCLES / 2);
      rx_bit_q <= '0;
    end else if (rx_busy_q) begin
      rx_tmr_q <= rx_tick ? `BIT_W'(BIT_CYCLES - 1) : rx_tmr_q - `BIT_W'(1);
      if (rx_tick) begin
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q != 4'h0 && !rx_done) begin
          rx_sh_q <= {line, rx_sh_q[7:1]};
        end
        if (rx_done) begin
          rx_busy_q <= 1'b0;
        end
      end
    end
  end

  // sequence: command, wait, frame, arm, count
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= abs_pos_pkg::HOST_IDLE;
      timer_q <= '0;
      idx_q <= '0;
      neg_q <= 1'b0;
      acc_q <= '0;
      serial_q <= '0;
      prev_q <= '0;
      pcount_q <= '0;
      err_q <= 1'b0;
    end else begin
      timer_q <= (state_q == abs_pos_pkg::HOST_WAIT) ?
        timer_q + `TIMER_W'(1) : '0;
      case (state_q)
        abs_pos_pkg::HOST_IDLE: begin
          if (sensor_on_req_i) begin
            state_q <= abs_pos_pkg::HOST_WAIT;
          end
        end
        abs_pos_pkg::HOST_WAIT: begin
          if (standby_done) begin
            state_q <= abs_pos_pkg::HOST_RECV;
            pcount_q <= '0;
            idx_q <= '0;
            neg_q <= 1'b0;
            acc_q <= '0;
            err_q <= 1'b0;
          end
        end
        abs_pos_pkg::HOST_RECV: begin
          if (rx_done) begin
            idx_q <= idx_q + 4'h1;
            if (rx_bad) begin
              err_q <= 1'b1;
            end
            if (idx_q == 4'h0) begin
              err_q <= err_q | rx_bad | (rx_char != `CHAR_P);
            end else if (idx_q == 4'h1) begin
              neg_q <= rx_char == `CHAR_MINUS;
            end else if (idx_q == `FRAME_CHARS - 4'h1) begin
              state_q <= abs_pos_pkg::HOST_ARM;
              err_q <= err_q | rx_bad | (rx_char != `CHAR_CR);
              serial_q <= neg_q ? `SERIAL_W'(-acc_q) : `SERIAL_W'(acc_q);
            end else begin
              acc_q <= acc_next;
            end
          end
        end
        abs_pos_pkg::HOST_ARM: begin
          if (!line) begin
            state_q <= abs_pos_pkg::HOST_COUNT;
            prev_q <= 2'h0;
          end
        end
        abs_pos_pkg::HOST_COUNT: begin
          prev_q <= quad;
          if (delta == 2'h1) begin
            pcount_q <= pcount_q + `POS_W'(1);
          end else if (delta == 2'h3) begin
            pcount_q <= pcount_q - `POS_W'(1);
          end
        end
        default: begin
          state_q <= abs_pos_pkg::HOST_IDLE;
        end
      endcase
      if (sensor_off_req_i) begin
        state_q <= abs_pos_pkg::HOST_IDLE;
      end
    end
  end

  // commands, origin watch and the absolute value
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      on_q <= 1'b0;
      off_q <= 1'b0;
      servo_q <= 1'b0;
      valid_q <= 1'b0;
      origin_q <= 1'b0;
      pos_q <= '0;
    end else begin
      on_q <= sensor_on_req_i & is_idle;
      off_q <= sensor_off_req_i;
      servo_q <= servo_on_req_i;
      valid_q <= is_count;
      // origin is only noted, it never resets the counter
      origin_q <= is_idle ? 1'b0 : origin_q | link.origin_pulse_out;
      pos_q <= pe - ps;
    end
  end

  assign link.sensor_on_command = on_q;
  assign link.sensor_off_command = off_q;
  assign link.servo_on_command = servo_q;
  assign position_valid_o = valid_q;
  assign abs_position_o = pos_q;
  assign frame_error_o = err_q;
  assign origin_seen_o = origin_q;
endmodule : abs_pos_host

// ===== verif/abs_link_monitor.sv
// link checker: timing of the frame start and of the pulse lines
`timescale 1ns/100ps
module abs_link_monitor #(
  parameter int STANDBY_CYCLES = 200
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sensor_on_command,
  input wire logic serial_and_phase_a_out,
  input wire logic phase_b_out,
  input wire logic origin_pulse_out
);
  localparam int LO = STANDBY_CYCLES - 24; // earliest first start bit
  localparam int HI = STANDBY_CYCLES + 8; // latest first start bit
  wire a = serial_and_phase_a_out; // short alias
  wire b = phase_b_out; // short alias
  wire o = origin_pulse_out; // short alias
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // line rests at mark for the first 8 cycles of the wait
  sequence mark_s;
    a [*8];
  endsequence
  // one of the phase lines moved
  sequence edge_s;
    $changed(a) || $changed(b);
  endsequence
  AST_CMD_ONE: assert property (
    sensor_on_command |=> !sensor_on_command)
    else $error("sensor on command longer than one cycle");
  AST_STANDBY: assert property (
    sensor_on_command |=> mark_s ##[LO:HI] $fell(a))
    else $error("first start bit outside the standby window");
  AST_QUIET: assert property (
    sensor_on_command |=> (!b && !o) [*8])
    else $error("phase b or origin active during standby");
  AST_QUAD: assert property (
    !($changed(a) && $changed(b)))
    else $error("both phases changed together");
  AST_STEP: assert property (
    $changed(b) |=> ($stable(a) && $stable(b)) [*8])
    else $error("pulse steps too close");
  AST_ORG_RISE: assert property (
    $rose(o) |-> edge_s)
    else $error("origin rise off a phase edge");
  AST_ORG_FALL: assert property (
    $fell(o) |-> edge_s)
    else $error("origin fall off a phase edge");
  AST_ORG_WIDTH: assert property (
    $rose(o) |-> o [*8])
    else $error("origin pulse too narrow");
endmodule : abs_link_monitor

// ===== verif/absolute_position_output_seq_tb.sv
// bench: both link ends joined; frame, value and command checks
`timescale 1ns/100ps
`include "abs_pos_defs.svh"
module absolute_position_output_seq_tb;
  localparam int ST = 200; // short standby
  localparam int BT = 16; // short bit time
  logic clk_i; // bench clock
  logic srst_i; // sync reset
  logic signed [`POS_W-1:0] pos; // scale position
  logic signed [`OFS_W-1:0] ofs; // origin offset
  logic signed [`SERIAL_W-1:0] ref_s; // reference serial value
  logic [`UNIT_BITS:0] ref_p; // reference pulses
  logic [7:0] alm; // alarm code
  logic [4:0] res; // output resolution shift
  logic dir, soff, on_r, off_r, sv_r; // stimulus levels
  logic energ, refused, valid, ferr, oseen; // flags seen
  logic [`POS_W-1:0] mc, absp; // coordinate and host value
  logic [6:0] exp_ch[$]; // expected characters
  logic [`POS_W-1:0] exp_v[$]; // expected value pairs
  int err_count = 0, tests_run = 0, n_ref = 0, stab = 0; // tallies
  logic prev_a, la, lb; // previous line levels
  abs_link_if link ();
  abs_pos_device #(.STANDBY_CYCLES(ST), .NORMAL_CYCLES(400),
    .BIT_CYCLES(BT)) i_abs_pos_device (.clk_i(clk_i), .srst_i(srst_i),
    .scale_position_i(pos), .output_resolution_setting_i(res),
    .direction_select_i(dir), .origin_offset_setting_i(ofs),
    .absolute_scale_i(1'b1), .alarm_code_i(alm), .servo_off_i(soff),
    .motor_energize_o(energ), .sensor_off_refused_o(refused),
    .machine_coordinate_position_o(mc), .link(link));
  abs_pos_host #(.STANDBY_CYCLES(ST), .BIT_CYCLES(BT)) i_abs_pos_host (
    .clk_i(clk_i), .srst_i(srst_i), .sensor_on_req_i(on_r),
    .sensor_off_req_i(off_r), .servo_on_req_i(sv_r), .ref_serial_i(ref_s),
    .ref_pulses_i(ref_p), .position_valid_o(valid), .abs_position_o(absp),
    .frame_error_o(ferr), .origin_seen_o(oseen), .link(link));
  abs_link_monitor #(.STANDBY_CYCLES(ST)) i_abs_link_monitor (
    .clk_i(clk_i), .srst_i(srst_i),
    .sensor_on_command(link.sensor_on_command),
    .serial_and_phase_a_out(link.serial_and_phase_a_out),
    .phase_b_out(link.phase_b_out), .origin_pulse_out(link.origin_pulse_out));
  // compare one result
  task automatic chk(string n, logic [39:0] e, logic [39:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // compare one flag
  task automatic chk_flag(string n, logic e, logic g);
    chk(n, 40'(e), 40'(g));
  endtask : chk_flag
  // compare one received character
  task automatic chk_char(logic [6:0] e, logic [6:0] g);
    chk("char", 40'(e), 40'(g));
  endtask : chk_char
  // report and stop
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // wait falling edges
  task automatic tk(int n);
    repeat (n) @(negedge clk_i);
  endtask : tk
  // one-cycle request
  task automatic pulse(ref logic s);
    s = 1'b1;
    tk(1);
    s = 1'b0;
  endtask : pulse
  // wait, bounded, until every expected result was seen
  task automatic drain;
    int k;
    for (k = 0; k < 9000 && (exp_ch.size() || exp_v.size()); k++) tk(1);
    if (k == 9000) begin
      err_count++;
      test_done();
    end
  endtask : drain
  // upper-case hex digit
  function automatic logic [6:0] hx(logic [3:0] v);
    return (v < 10) ? 7'h30 + 7'(v) : 7'h37 + 7'(v);
  endfunction : hx
  initial begin : clk_proc
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // decoder: characters on line a against the queue
  always begin : rx_proc
    logic [9:0] b;
    @(posedge clk_i);
    if (exp_ch.size() != 0 && prev_a && !link.serial_and_phase_a_out) begin
      repeat (BT / 2) @(posedge clk_i);
      for (int i = 0; i < 10; i++) begin
        b[i] = link.serial_and_phase_a_out;
        if (i < 9) repeat (BT) @(posedge clk_i);
      end
      chk_char(exp_ch.pop_front(), b[7:1]);
      chk("framing", 40'h1, 40'({^b[8:1], b[0], b[9]}));
    end
    prev_a = link.serial_and_phase_a_out;
  end
  // value watcher: compares once the phase lines have rested
  always @(posedge clk_i) begin : val_proc
    if (link.serial_and_phase_a_out !== la || link.phase_b_out !== lb) begin
      stab = 0;
    end else begin
      stab++;
    end
    la = link.serial_and_phase_a_out;
    lb = link.phase_b_out;
    if (refused === 1'b1) n_ref++;
    if (valid === 1'b1 && stab == 60 && exp_v.size() != 0) begin
      chk("host value", exp_v.pop_front(), absp);
      chk("coordinate", exp_v.pop_front(), mc);
      chk_flag("frame error", 1'b0, ferr);
      chk_flag("origin seen", 1'b1, oseen);
    end
  end
  initial begin : main_proc
    int m, r;
    logic [15:0] rs;
    longint e;
    srst_i = 1'b1;
    {pos, ofs, ref_s, ref_p, alm, res, dir, soff, on_r, off_r, sv_r} = '0;
    {prev_a, la, lb} = '0;
    void'($urandom(32'h0bf74e4a));
    for (int it = 0; it < 3; it++) begin
      srst_i = 1'b1;
      tk(12);
      srst_i = 1'b0;
      r = 4 * (1 + $urandom % 3);
      rs = (it == 1) ? 16'h8000 : 16'($urandom);
      ref_s = 16'($urandom % 64);
      ref_p = 21'($urandom % 1048577);
      ofs = $signed(31'($urandom)) >>> 1;
      alm = 8'($urandom);
      dir = (it == 2);
      res = 5'(it);
      pos = {(it == 1) ? 4'h0 : {4{rs[15]}}, rs, 20'(r)} << res;
      m = rs[15] ? 65536 - int'(rs) : int'(rs);
      exp_ch.push_back(`CHAR_P);
      exp_ch.push_back((rs[15] ^ dir) ? `CHAR_MINUS : `CHAR_PLUS);
      for (int d = 10000; d > 0; d /= 10)
        exp_ch.push_back(7'(`CHAR_ZERO + m / d % 10));
      exp_ch.push_back(`CHAR_CR);
      // the host reads the sign character as sent, reversed mode too
      e = longint'((rs[15] ^ dir) ? -m : m) * 1048576 + r;
      e = e - longint'(ref_s) * 1048576 - ref_p;
      exp_v.push_back(40'(e));
      exp_v.push_back(40'(pos + ofs));
      pulse(on_r);
      tk(20);
      pulse(sv_r);
      drain();
      chk_flag("energize", 1'b0, energ);
      tk(500);
      pos = pos + (40'(3) << res);
      exp_v.push_back(40'(e + 3));
      exp_v.push_back(40'(pos + ofs));
      drain();
      pulse(sv_r);
      tk(4);
      chk_flag("energize", 1'b1, energ);
      pulse(off_r);
      tk(4);
      chk("refusals", 40'(it + 1), 40'(n_ref));
      soff = 1'b1;
      tk(3);
      soff = 1'b0;
      exp_ch.push_back(`CHAR_A);
      exp_ch.push_back(hx(alm[7:4]));
      exp_ch.push_back(hx(alm[3:0]));
      exp_ch.push_back(`CHAR_CR);
      pulse(off_r);
      drain();
    end
    test_done();
  end
endmodule : absolute_position_output_seq_tb
